/* design/ssf_cfg.svh */
// Sizes, defaults and reset values of the stream sample formatter
`ifndef SSF_CFG_SVH
`define SSF_CFG_SVH

`define SSF_BYTE_W        8
`define SSF_SAMP_W        12
`define SSF_FIELD_BYTES   2
`define SSF_OUT_BYTES     4
`define SSF_USER_W        1
`define SSF_FIFO_DEPTH    32
`define SSF_BLK_LEN_W     16
`define SSF_STAT_W        16
`define SSF_RST_STATE     '0

`endif

/* design/ssf_pkg.sv */
// Types shared by the stream sample formatter files
package ssf_pkg;

  // How the native sample bits are to be read
  typedef enum logic [1:0] {
    SSF_NUM_UNSIGNED,
    SSF_NUM_SIGNED,
    SSF_NUM_FLOAT
  } ssf_num_t;

endpackage : ssf_pkg

/* design/ssf_fifo.sv */
// First-in first-out buffer with a registered read word and valid/ready on both sides
`include "ssf_cfg.svh"

module ssf_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = `SSF_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  import ssf_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [CW-1:0]           cnt;
    logic [W-1:0]            rdata;
    logic                    rvalid;
  } ssf_fifo_state_t;

  ssf_fifo_state_t q;
  ssf_fifo_state_t next_q;
  logic            push;
  logic            load;

  // Memory words plus the output register: one more than DEPTH can be in flight
  assign in_ready  = (q.cnt != CW'(DEPTH));
  assign push      = in_valid && in_ready;
  assign load      = (!q.rvalid || out_ready) && (q.cnt != '0);
  assign out_valid = q.rvalid;
  assign out_data  = q.rdata;

  always_comb
  begin
    next_q = q;
    if (push)
    begin
      next_q.mem[q.wr] = in_data;
      next_q.wr        = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + AW'(1);
    end
    if (load)
    begin
      next_q.rdata  = q.mem[q.rd];
      next_q.rvalid = 1'b1;
      next_q.rd     = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + AW'(1);
    end
    else if (out_ready)
    begin
      next_q.rvalid = 1'b0;
    end
    next_q.cnt = q.cnt + CW'(push) - CW'(load);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      q <= `SSF_RST_STATE;
    else
      q <= next_q;
  end

endmodule : ssf_fifo

/* design/ssf_formatter.sv */
// Stream sample formatter: byte extension, complex ordering, packing and splitting
`include "ssf_cfg.svh"

module ssf_formatter #(
  parameter int SAMP_W      = `SSF_SAMP_W,
  parameter int FIELD_BYTES = `SSF_FIELD_BYTES,
  parameter int OUT_BYTES   = `SSF_OUT_BYTES,
  parameter int USER_W      = `SSF_USER_W,
  parameter int FIFO_DEPTH  = `SSF_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rstn,
  // Configuration levels
  input  wire ssf_pkg::ssf_num_t           cfg_num,
  input  wire logic                        cfg_cplx,
  input  wire logic [`SSF_BLK_LEN_W-1:0]   cfg_block_len,
  // Native sample input
  input  wire logic                        smp_valid,
  output logic                             smp_ready,
  input  wire logic [SAMP_W-1:0]           smp_re,
  input  wire logic [SAMP_W-1:0]           smp_im,
  input  wire logic [USER_W-1:0]           smp_user,
  input  wire logic                        smp_last,
  // Byte-aligned output stream
  output logic                             m_axis_tvalid,
  input  wire logic                        m_axis_tready,
  output logic [OUT_BYTES*8-1:0]           m_axis_tdata,
  output logic [OUT_BYTES-1:0]             m_axis_tkeep,
  output logic [USER_W*((OUT_BYTES >= FIELD_BYTES) ? OUT_BYTES / FIELD_BYTES : 1)-1:0]
                                           m_axis_tuser,
  output logic                             m_axis_tlast,
  // Status
  output logic                             busy,
  output logic [`SSF_STAT_W-1:0]           beat_count,
  output logic [`SSF_STAT_W-1:0]           block_count
);
  import ssf_pkg::*;

  localparam int FIELD_W = FIELD_BYTES * `SSF_BYTE_W;
  localparam int OUT_W   = OUT_BYTES * `SSF_BYTE_W;
  localparam bit SPLIT   = (OUT_BYTES < FIELD_BYTES);
  localparam int PACK_N  = SPLIT ? 1 : OUT_BYTES / FIELD_BYTES;
  localparam int SPLIT_N = SPLIT ? FIELD_BYTES / OUT_BYTES : 1;
  localparam int MAX_W   = SPLIT ? FIELD_W : OUT_W;
  localparam int UO_W    = USER_W * PACK_N;
  localparam int KB_W    = MAX_W / `SSF_BYTE_W;
  localparam int CNT_W   = $clog2(PACK_N + 1);
  localparam int IDX_W   = $clog2(SPLIT_N + 1);
  localparam int EW      = FIELD_W + USER_W + 1;
  localparam int LW      = `SSF_BLK_LEN_W;
  localparam int SW      = `SSF_STAT_W;

  typedef struct packed {
    // Front end: imaginary part waiting for its serial slot, and the block sample count
    logic                pend;
    logic [FIELD_W-1:0]  hold;
    logic [USER_W-1:0]   hold_user;
    logic                hold_last;
    logic [LW-1:0]       blk_cnt;
    // Packer accumulator and split slice index
    logic [MAX_W-1:0]    acc;
    logic [UO_W-1:0]     acc_user;
    logic [KB_W-1:0]     acc_keep;
    logic [CNT_W-1:0]    cnt;
    logic [IDX_W-1:0]    idx;
    // Output register
    logic                o_valid;
    logic [OUT_W-1:0]    o_data;
    logic [OUT_BYTES-1:0] o_keep;
    logic [UO_W-1:0]     o_user;
    logic                o_last;
    // Statistics
    logic [SW-1:0]       beats;
    logic [SW-1:0]       blocks;
  } ssf_fmt_state_t;

  ssf_fmt_state_t q;
  ssf_fmt_state_t next_q;

  logic [FIELD_W-1:0]  re_f;
  logic [FIELD_W-1:0]  im_f;
  logic                ext_sign;
  logic                blk_end;
  logic                last_in;
  logic                fin_valid;
  logic                fin_ready;
  logic [EW-1:0]       fin_data;
  logic                fout_valid;
  logic                fout_ready;
  logic [EW-1:0]       fout_data;
  logic [FIELD_W-1:0]  f_field;
  logic [USER_W-1:0]   f_user;
  logic                f_last;
  logic [MAX_W-1:0]    f_wide;
  logic                can_take;
  logic                take;
  logic [MAX_W-1:0]    t_acc;
  logic [UO_W-1:0]     t_user;
  logic [KB_W-1:0]     t_keep;
  logic                emit;

  // Floats are zero padded: copying the sign would corrupt the exponent
  assign ext_sign = (cfg_num == SSF_NUM_SIGNED);

  // Per-bit extension of both components into their byte-multiple fields
  for (genvar b = 0; b < FIELD_W; b++)
  begin : g_ext
    if (b < SAMP_W)
    begin : g_keep
      assign re_f[b] = smp_re[b];
      assign im_f[b] = smp_im[b];
    end
    else
    begin : g_pad
      assign re_f[b] = ext_sign & smp_re[SAMP_W-1];
      assign im_f[b] = ext_sign & smp_im[SAMP_W-1];
    end
  end

  // Block mode: a non-zero length forces an end mark after that many samples
  assign blk_end = (cfg_block_len != '0) && (q.blk_cnt == cfg_block_len - LW'(1));
  assign last_in = smp_last || blk_end;

  assign f_field = fout_data[FIELD_W-1:0];
  assign f_user  = fout_data[FIELD_W +: USER_W];
  assign f_last  = fout_data[EW-1];
  assign f_wide  = MAX_W'(f_field);

  // The output register is free when empty or being taken this edge
  assign can_take = !q.o_valid || m_axis_tready;
  assign take     = fout_valid && can_take;

  ssf_fifo #(
    .W     (EW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (fin_valid),
    .in_ready  (fin_ready),
    .in_data   (fin_data),
    .out_valid (fout_valid),
    .out_ready (fout_ready),
    .out_data  (fout_data)
  );

  always_comb
  begin
    next_q    = q;
    fin_valid = 1'b0;
    fin_data  = '0;
    smp_ready = 1'b0;
    fout_ready = 1'b0;
    t_acc     = q.acc;
    t_user    = q.acc_user;
    t_keep    = q.acc_keep;
    emit      = 1'b0;

    // Front end: one field per entry, imaginary part parked for the next slot
    if (q.pend)
    begin
      fin_valid = 1'b1;
      fin_data  = {q.hold_last, q.hold_user, q.hold};
      if (fin_ready)
        next_q.pend = 1'b0;
    end
    else
    begin
      fin_valid = smp_valid;
      smp_ready = fin_ready;
      fin_data  = {last_in && !cfg_cplx, smp_user, re_f};
      if (smp_valid && fin_ready)
      begin
        next_q.blk_cnt = last_in ? '0 : q.blk_cnt + LW'(1);
        if (cfg_cplx)
        begin
          next_q.pend      = 1'b1;
          next_q.hold      = im_f;
          next_q.hold_user = smp_user;
          next_q.hold_last = last_in;
        end
      end
    end

    // Output register empties when the far end takes the beat
    if (q.o_valid && m_axis_tready)
    begin
      next_q.o_valid = 1'b0;
      next_q.beats   = q.beats + SW'(1);
      if (q.o_last)
        next_q.blocks = q.blocks + SW'(1);
    end

    if (SPLIT)
    begin
      // Wide field goes out lowest bytes first, one beat per slice
      fout_ready = can_take && (q.idx == IDX_W'(SPLIT_N - 1));
      if (take)
      begin
        for (int k = 0; k < SPLIT_N; k++)
        begin
          if (q.idx == IDX_W'(k))
            next_q.o_data = f_wide[k*OUT_W +: OUT_W];
        end
        next_q.o_keep  = '1;
        next_q.o_user  = UO_W'(f_user);
        next_q.o_last  = f_last && (q.idx == IDX_W'(SPLIT_N - 1));
        next_q.o_valid = 1'b1;
        next_q.idx     = (q.idx == IDX_W'(SPLIT_N - 1)) ? '0 : q.idx + IDX_W'(1);
      end
    end
    else
    begin
      // Fields fill slots upward, so earlier samples and real parts sit low
      fout_ready = can_take;
      if (take)
      begin
        for (int k = 0; k < PACK_N; k++)
        begin
          if (q.cnt == CNT_W'(k))
          begin
            t_acc[k*FIELD_W +: FIELD_W]   = f_field;
            t_user[k*USER_W +: USER_W]    = f_user;
            t_keep[k*FIELD_BYTES +: FIELD_BYTES] = '1;
          end
        end
        emit = f_last || (q.cnt == CNT_W'(PACK_N - 1));
        if (emit)
        begin
          // Slots never written stay zero from the cleared accumulator
          next_q.o_data   = t_acc[OUT_W-1:0];
          next_q.o_keep   = t_keep[OUT_BYTES-1:0];
          next_q.o_user   = t_user;
          next_q.o_last   = f_last;
          next_q.o_valid  = 1'b1;
          next_q.acc      = '0;
          next_q.acc_user = '0;
          next_q.acc_keep = '0;
          next_q.cnt      = '0;
        end
        else
        begin
          next_q.acc      = t_acc;
          next_q.acc_user = t_user;
          next_q.acc_keep = t_keep;
          next_q.cnt      = q.cnt + CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      q <= `SSF_RST_STATE;
    else
      q <= next_q;
  end

  // Output register holds until taken, so data never moves under a stalled beat
  assign m_axis_tvalid = q.o_valid;
  assign m_axis_tdata  = q.o_data;
  assign m_axis_tkeep  = q.o_keep;
  assign m_axis_tuser  = q.o_user;
  assign m_axis_tlast  = q.o_last;

  // The buffer's read word counts through fout_valid
  assign busy        = q.pend || fout_valid || q.o_valid || (q.cnt != '0) || (q.idx != '0);
  assign beat_count  = q.beats;
  assign block_count = q.blocks;

endmodule : ssf_formatter

/* testbench/ssf_formatter_props.sv */
// Concurrent checks on the formatter output stream and input handshake
module ssf_formatter_props
  import ssf_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Configuration and input handshake
  input wire ssf_num_t    cfg_num,
  input wire logic        cfg_cplx,
  input wire logic        smp_valid,
  input wire logic        smp_ready,
  // Output stream and status
  input wire logic        m_axis_tvalid,
  input wire logic        m_axis_tready,
  input wire logic [31:0] m_axis_tdata,
  input wire logic [3:0]  m_axis_tkeep,
  input wire logic        m_axis_tlast,
  input wire logic        busy,
  input wire logic [15:0] beat_count,
  input wire logic [15:0] block_count
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_reset_quiet: assert property (disable iff (1'b0) !rstn |-> !m_axis_tvalid && beat_count == 0)
    else $error("output active in reset");
  a_stall_hold: assert property (m_axis_tvalid && !m_axis_tready |=> m_axis_tvalid
    && $stable(m_axis_tdata) && $stable(m_axis_tkeep) && $stable(m_axis_tlast))
    else $error("beat changed while stalled");
  a_beat_step: assert property (m_axis_tvalid && m_axis_tready |=> beat_count == $past(beat_count) + 16'h1)
    else $error("beat count missed a beat");
  a_block_step: assert property (m_axis_tvalid && m_axis_tready && m_axis_tlast
    |=> block_count == $past(block_count) + 16'h1) else $error("block count missed");
  a_block_hold: assert property (!(m_axis_tvalid && m_axis_tready && m_axis_tlast) |=> $stable(block_count))
    else $error("block count moved without block end");
  a_keep_shape: assert property (m_axis_tvalid |-> m_axis_tkeep == 4'hf || (m_axis_tkeep == 4'h3
    && m_axis_tlast && m_axis_tdata[31:16] == 16'h0)) else $error("bad partial word");
  a_zero_pad: assert property (m_axis_tvalid && cfg_num != SSF_NUM_SIGNED |-> m_axis_tdata[15:12] == 4'h0
    && (!m_axis_tkeep[2] || m_axis_tdata[31:28] == 4'h0)) else $error("pad not zero");
  a_sign_pad: assert property (m_axis_tvalid && cfg_num == SSF_NUM_SIGNED
    |-> m_axis_tdata[15:12] == {4{m_axis_tdata[11]}}) else $error("pad not sign copies");
  a_cplx_gap: assert property (smp_valid && smp_ready && cfg_cplx |=> !smp_ready)
    else $error("second sample taken while imaginary part pending");
  a_busy_out: assert property (m_axis_tvalid |-> busy)
    else $error("busy low with beat waiting");
endmodule : ssf_formatter_props

bind ssf_formatter ssf_formatter_props i_props (.clk(clk), .rstn(rstn), .cfg_num(cfg_num),
  .cfg_cplx(cfg_cplx), .smp_valid(smp_valid), .smp_ready(smp_ready),
  .m_axis_tvalid(m_axis_tvalid), .m_axis_tready(m_axis_tready), .m_axis_tdata(m_axis_tdata),
  .m_axis_tkeep(m_axis_tkeep), .m_axis_tlast(m_axis_tlast), .busy(busy),
  .beat_count(beat_count), .block_count(block_count));

/* testbench/ssf_sink.sv */
// Downstream sink: accepts promptly, at random, or not at all
module ssf_sink (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // Acceptance style
  input wire logic [1:0] mode,
  output logic           tready
);
  timeunit 1ns;
  timeprecision 1ns;
  initial tready = 1'b0;
  // Ready ignores valid, so stalls land on any beat, the awkward case included
  always @(posedge clk)
    tready <= #1 !rstn ? 1'b0 : (mode == 2'h0) ? 1'b1 : (mode == 2'h1) ? 1'($urandom_range(1)) : 1'b0;
endmodule : ssf_sink

/* testbench/ssf_formatter_bench.sv */
// Self-checking bench for the stream sample formatter
module ssf_formatter_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import ssf_pkg::*;
  typedef struct packed {logic [31:0] d; logic [3:0] k; logic l; logic [1:0] u;} ssf_beat_t;
  logic        clk = 1'b0, rstn = 1'b1, smp_valid = 1'b0, smp_last = 1'b0, smp_user = 1'b0;
  logic        cfg_cplx = 1'b0, tready, tvalid, tlast, busy, smp_ready;
  ssf_num_t    cfg_num = SSF_NUM_UNSIGNED;
  logic [15:0] blen = 16'h0, beat_count, block_count;
  logic [11:0] smp_re = 12'h0, smp_im = 12'h0;
  logic [31:0] tdata;
  logic [3:0]  tkeep;
  logic [1:0]  tuser, mode = 2'h0;
  ssf_beat_t   exp_q[$], acc;
  bit          slot;
  int          scnt, mismatches, comparisons, nbeat, nblk;

  ssf_formatter i_dut (.clk(clk), .rstn(rstn), .cfg_num(cfg_num), .cfg_cplx(cfg_cplx),
    .cfg_block_len(blen), .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_re(smp_re),
    .smp_im(smp_im), .smp_user(smp_user), .smp_last(smp_last), .m_axis_tvalid(tvalid),
    .m_axis_tready(tready), .m_axis_tdata(tdata), .m_axis_tkeep(tkeep), .m_axis_tuser(tuser),
    .m_axis_tlast(tlast), .busy(busy), .beat_count(beat_count), .block_count(block_count));
  ssf_sink i_sink (.clk(clk), .rstn(rstn), .mode(mode), .tready(tready));

  initial forever #10 clk = ~clk;

  task automatic close_out;
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk(input bit ok, input string m);
    comparisons++;
    if (!ok)
    begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  function automatic logic [15:0] ext(input logic [11:0] v);
    return (cfg_num == SSF_NUM_SIGNED) ? {{4{v[11]}}, v} : {4'h0, v};
  endfunction : ext
  task automatic put(input logic [15:0] f, input logic u, input logic l);
    if (!slot) acc = '{d: {16'h0, f}, k: 4'h3, l: l, u: {1'b0, u}};
    else acc = '{d: {f, acc.d[15:0]}, k: 4'hf, l: l, u: {u, acc.u[0]}};
    slot = !slot;
    if (l || !slot)
    begin
      exp_q.push_back(acc);
      slot = 1'b0;
    end
  endtask : put
  // Entered and left one delay after an edge; valid stays up for a back-to-back caller
  task automatic send(input logic l, output bit ok);
    int n;
    smp_valid = 1'b1;
    smp_re = 12'($urandom);
    smp_im = 12'($urandom);
    smp_user = 1'($urandom);
    smp_last = l;
    ok = 1'b0;
    // Ready is read mid-cycle, where it has settled, so the take edge is never misjudged
    for (n = 0; n < 200 && !ok; n++)
    begin
      @(negedge clk);
      ok = smp_ready;
      @(posedge clk);
    end
    if (ok)
    begin
      scnt++;
      l = l || (blen != 16'h0 && scnt == int'(blen));
      if (l) scnt = 0;
      put(ext(smp_re), smp_user, l && !cfg_cplx);
      if (cfg_cplx) put(ext(smp_im), smp_user, l);
    end
    #1;
  endtask : send
  task automatic drain;
    int n;
    smp_valid = 1'b0;
    for (n = 0; n < 500 && (busy !== 1'b0 || exp_q.size() != 0); n++) @(posedge clk);
    if (n == 500)
    begin
      chk(1'b0, "drain timed out");
      close_out();
    end
    #1;
  endtask : drain
  task automatic cmp_beat(input ssf_beat_t e);
    chk(tdata === e.d && tkeep === e.k, "data lanes");
    chk(tlast === e.l, "block end");
    chk(tuser[0] === e.u[0] && (!e.k[2] || tuser[1] === e.u[1]), "sideband");
  endtask : cmp_beat

  always @(posedge clk)
    if (rstn && tvalid === 1'b1 && tready === 1'b1)
    begin
      nbeat++;
      if (tlast === 1'b1) nblk++;
      if (exp_q.size() == 0) chk(1'b0, "unexpected beat");
      else cmp_beat(exp_q.pop_front());
    end

  initial
  begin
    bit ok;
    int k;
    void'($urandom(32'hb00ecb34));
    rstn = 1'b0;
    repeat (6) @(posedge clk);
    #1 rstn = 1'b1;
    // Every number kind, real and complex, prompt and stalling sink, then block length
    for (int c = 0; c < 6; c++)
    begin
      cfg_num = ssf_num_t'(c % 3);
      cfg_cplx = 1'(c / 3);
      mode = 2'(c % 2);
      blen = (c == 5) ? 16'h3 : 16'h0;
      for (int i = 0; i < 8; i++)
      begin
        send(i == 7, ok);
        chk(ok, "sample refused");
      end
      drain();
    end
    // Fill the buffer against a stopped sink until it refuses
    cfg_cplx = 1'b0;
    mode = 2'h2;
    k = 0;
    ok = 1'b1;
    while (ok && k < 100)
    begin
      send(1'b0, ok);
      k += int'(ok);
    end
    chk(k >= 32 && k < 100, "no back-pressure");
    mode = 2'h0;
    send(1'b1, ok);
    drain();
    chk(beat_count === nbeat[15:0] && block_count === nblk[15:0], "status counts");
    close_out();
  end
endmodule : ssf_formatter_bench
